/* File: verilog/smc_supply_monitor_control.sv */
/*
  Control and status logic of the supply drop monitor and its early warning
  monitor, reached over APB. Fuse values, sleep state, comparator output and
  the unlock key strobe come from surrounding logic, synchronous to mclk.
*/
// Design decision made here: register access over APB.
`timescale 1ns/1ns
`default_nettype none

module smc_supply_monitor_control #(
  parameter int unsigned FAST_PERIOD = smc_pkg::FAST_CYCLES,
  parameter int unsigned SLOW_PERIOD = smc_pkg::SLOW_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register bus
  input wire smc_pkg::smc_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fuse values, held stable by the fuse loader
  input wire smc_pkg::smc_fuse_t fuse,
  // processor side
  input wire logic unlock_key_written,
  input wire logic instr_retired,
  input wire logic deep_sleep,
  output logic hold_execution,
  // analog side
  input wire logic warn_below_raw,
  input wire logic monitor_ready,
  output var smc_pkg::smc_analog_ctrl_t analog_ctrl,
  // interrupt request
  output logic warn_irq
);

  function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
    reg_hit = (addr[1:0] == 2'b00) && (addr[7:2] == idx);
  endfunction : reg_hit

  // state
  logic fuse_loaded;
  logic sample_rate;
  logic [1:0] active_mode;
  logic [1:0] sleep_mode;
  logic [2:0] threshold;
  logic [1:0] warn_offset;
  logic [1:0] warn_edge;
  logic warn_ie;
  logic warn_flag;
  logic warn_below;
  logic [2:0] unlock_cnt;
  smc_pkg::smc_power_state_t pstate;
  smc_pkg::smc_power_state_t next_pstate;

  // bus decode
  wire logic bus_setup = apb_req.psel && !apb_req.penable;
  wire logic bus_access = apb_req.psel && apb_req.penable;
  wire logic bus_wr = bus_access && apb_req.pwrite;
  wire logic [7:0] addr = apb_req.paddr;
  wire logic [31:0] wdata = apb_req.pwdata;
  wire logic hit_ctrl = reg_hit(addr, smc_pkg::IDX_MONITOR_MODE_CTRL);
  wire logic hit_thr = reg_hit(addr, smc_pkg::IDX_THRESHOLD_LEVEL);
  wire logic hit_wlvl = reg_hit(addr, smc_pkg::IDX_EARLY_WARN_LEVEL);
  wire logic hit_irqc = reg_hit(addr, smc_pkg::IDX_WARN_IRQ_CTRL);
  wire logic hit_flag = reg_hit(addr, smc_pkg::IDX_WARN_IRQ_FLAGS);
  wire logic hit_state = reg_hit(addr, smc_pkg::IDX_WARN_STATE);
  wire logic hit_resv = (addr[1:0] == 2'b00) && (addr[7:2] >= smc_pkg::IDX_RESERVED_FIRST)
                        && (addr[7:2] <= smc_pkg::IDX_RESERVED_LAST);
  wire logic hit_any = hit_ctrl || hit_thr || hit_wlvl || hit_irqc || hit_flag
                       || hit_state || hit_resv;

  // zero-wait slave: every access phase completes in its first cycle
  assign pready = bus_access;

  wire logic unlocked = (unlock_cnt != 3'h0);
  wire logic ctrl_wr = bus_wr && hit_ctrl;
  wire logic sleep_wr = ctrl_wr && unlocked;
  logic [2:0] next_unlock_cnt;
  // the key reloads the window; any control write, honoured or not, spends it unless the key comes in the same cycle
  assign next_unlock_cnt = unlock_key_written ? smc_pkg::UNLOCK_WINDOW_INSTR :
                           ctrl_wr ? 3'h0 :
                           (instr_retired && unlocked) ? unlock_cnt - 3'h1 : unlock_cnt;

  wire logic in_sleep = (pstate == smc_pkg::PS_SLEEP);
  wire logic [1:0] eff_mode = in_sleep ? sleep_mode : active_mode;
  // reserved sleep code three is treated as disabled
  wire logic mon_on = fuse_loaded && (eff_mode != smc_pkg::MODE_DISABLED)
                      && !(in_sleep && eff_mode == smc_pkg::MODE_CONTINUOUS_HOLD);
  wire logic mon_sampled = mon_on && (eff_mode == smc_pkg::MODE_SAMPLED);

  wire logic warn_on = mon_on && (warn_offset != smc_pkg::WARN_OFFSET_OFF);
  logic sample_strobe;

  smc_sampler #(
    .FAST_PERIOD(FAST_PERIOD),
    .SLOW_PERIOD(SLOW_PERIOD)
  ) u_sampler (
    .mclk(mclk),
    .rst(rst),
    .run(mon_sampled),
    .slow(sample_rate),
    .strobe(sample_strobe)
  );

  wire logic warn_take = warn_on && (!mon_sampled || sample_strobe);
  wire logic crossing = warn_take && (warn_below_raw != warn_below);
  wire logic edge_match = (warn_edge == smc_pkg::EDGE_FALLING) ? warn_below_raw :
                          (warn_edge == smc_pkg::EDGE_RISING) ? !warn_below_raw :
                          (warn_edge == smc_pkg::EDGE_BOTH);
  wire logic flag_set = crossing && edge_match;
  wire logic flag_clr = bus_wr && hit_flag && wdata[smc_pkg::WARN_IRQ_FLAG_BIT];
  // set wins over clear; when off, only a clear write changes it
  wire logic next_warn_flag = flag_set || (warn_flag && !flag_clr);
  wire logic next_warn_below = warn_take ? warn_below_raw : warn_below;

  assign warn_irq = warn_ie && warn_flag;

  always_comb
  begin
    next_pstate = pstate;
    case (pstate)
      smc_pkg::PS_RUN:
        if (deep_sleep)
          next_pstate = smc_pkg::PS_SLEEP;
      smc_pkg::PS_SLEEP:
        if (!deep_sleep)
          next_pstate = (active_mode == smc_pkg::MODE_CONTINUOUS_HOLD) ?
                        smc_pkg::PS_WAKE_HOLD : smc_pkg::PS_RUN;
      smc_pkg::PS_WAKE_HOLD:
        if (monitor_ready)
          next_pstate = smc_pkg::PS_RUN;
      default:
        next_pstate = smc_pkg::PS_RUN;
    endcase
  end

  assign hold_execution = (pstate == smc_pkg::PS_WAKE_HOLD);

  // read data, captured in the setup cycle
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit_ctrl)
    begin
      next_rdata[smc_pkg::SAMPLE_RATE_BIT] = sample_rate;
      next_rdata[smc_pkg::ACTIVE_MODE_LSB +: 2] = active_mode;
      next_rdata[smc_pkg::SLEEP_MODE_LSB +: 2] = sleep_mode;
    end
    else if (hit_thr)
      next_rdata[smc_pkg::THRESHOLD_LSB +: 3] = threshold;
    else if (hit_wlvl)
      next_rdata[smc_pkg::WARN_OFFSET_LSB +: 2] = warn_offset;
    else if (hit_irqc)
    begin
      next_rdata[smc_pkg::WARN_EDGE_LSB +: 2] = warn_edge;
      next_rdata[smc_pkg::WARN_IRQ_ENABLE_BIT] = warn_ie;
    end
    else if (hit_flag)
      next_rdata[smc_pkg::WARN_IRQ_FLAG_BIT] = warn_flag;
    else if (hit_state)
      next_rdata[smc_pkg::WARN_BELOW_BIT] = warn_below;
  end

  smc_pkg::smc_analog_ctrl_t next_analog_ctrl;
  always_comb
  begin
    next_analog_ctrl.monitor_on = mon_on;
    next_analog_ctrl.monitor_sampled = mon_sampled;
    next_analog_ctrl.sample_rate_sel = sample_rate;
    next_analog_ctrl.threshold_sel = threshold;
    next_analog_ctrl.warn_on = warn_on;
    next_analog_ctrl.warn_offset_sel = warn_offset;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fuse_loaded <= 1'b0;
      sample_rate <= 1'b0;
      active_mode <= smc_pkg::RESET_MODE;
      threshold <= smc_pkg::RESET_THRESHOLD;
    end
    else if (!fuse_loaded)
    begin
      fuse_loaded <= 1'b1;
      sample_rate <= fuse.sample_rate_sel;
      active_mode <= fuse.active_mode;
      threshold <= fuse.threshold_sel;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sleep_mode <= smc_pkg::RESET_MODE;
    else if (!fuse_loaded)
      sleep_mode <= fuse.sleep_mode;
    else if (sleep_wr)
      sleep_mode <= wdata[smc_pkg::SLEEP_MODE_LSB +: 2];
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      warn_offset <= smc_pkg::RESET_WARN_OFFSET;
      warn_edge <= smc_pkg::RESET_WARN_EDGE;
      warn_ie <= 1'b0;
    end
    else
    begin
      if (bus_wr && hit_wlvl)
        warn_offset <= wdata[smc_pkg::WARN_OFFSET_LSB +: 2];
      if (bus_wr && hit_irqc)
      begin
        warn_edge <= wdata[smc_pkg::WARN_EDGE_LSB +: 2];
        warn_ie <= wdata[smc_pkg::WARN_IRQ_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      warn_flag <= 1'b0;
      warn_below <= 1'b0;
      unlock_cnt <= 3'h0;
      pstate <= smc_pkg::PS_RUN;
    end
    else
    begin
      warn_flag <= next_warn_flag;
      warn_below <= next_warn_below;
      unlock_cnt <= next_unlock_cnt;
      pstate <= next_pstate;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= smc_pkg::RESET_RDATA;
      pslverr <= 1'b0;
      analog_ctrl <= '0;
    end
    else
    begin
      if (bus_setup)
      begin
        prdata <= next_rdata;
        pslverr <= !hit_any;
      end
      analog_ctrl <= next_analog_ctrl;
    end
  end

  property p_irq_follows_flag;
    @(posedge mclk) disable iff (rst)
    (warn_ie && flag_set && !(bus_wr && hit_irqc)) |=> warn_irq && warn_flag;
  endproperty
  a_irq_follows_flag: assert property (p_irq_follows_flag)
    else $error("warning request missing after enabled flag set");

  property p_flag_holds_when_off;
    @(posedge mclk) disable iff (rst)
    (!mon_on && !flag_clr) |=> (warn_flag == $past(warn_flag));
  endproperty
  a_flag_holds_when_off: assert property (p_flag_holds_when_off)
    else $error("warning flag changed while monitor off");

  property p_locked_write_ignored;
    @(posedge mclk) disable iff (rst)
    (fuse_loaded && ctrl_wr && unlock_cnt == 3'h0 && !unlock_key_written)
      |=> $stable(sleep_mode);
  endproperty
  a_locked_write_ignored: assert property (p_locked_write_ignored)
    else $error("sleep mode changed without unlock");

  property p_window_expires;
    @(posedge mclk) disable iff (rst)
    (unlock_key_written ##1 (!unlock_key_written && instr_retired && !ctrl_wr) [*4])
      |=> !unlocked;
  endproperty
  a_window_expires: assert property (p_window_expires)
    else $error("unlock window outlived four instructions");

  property p_active_mode_read_only;
    @(posedge mclk) disable iff (rst)
    (fuse_loaded && ctrl_wr) |=> $stable(active_mode) && $stable(sample_rate);
  endproperty
  a_active_mode_read_only: assert property (p_active_mode_read_only)
    else $error("read-only monitor mode bits were written");

  property p_edge_sets_flag;
    @(posedge mclk) disable iff (rst)
    (mon_on && crossing && warn_edge == smc_pkg::EDGE_BOTH) |=> warn_flag;
  endproperty
  a_edge_sets_flag: assert property (p_edge_sets_flag)
    else $error("crossing did not set warning flag");

  property p_reserved_edge_quiet;
    @(posedge mclk) disable iff (rst)
    (warn_edge == 2'h3 && !warn_flag) |=> !warn_flag;
  endproperty
  a_reserved_edge_quiet: assert property (p_reserved_edge_quiet)
    else $error("reserved edge code set the flag");

  property p_status_tracks;
    @(posedge mclk) disable iff (rst)
    (warn_on && !mon_sampled) |=> (warn_below == $past(warn_below_raw));
  endproperty
  a_status_tracks: assert property (p_status_tracks)
    else $error("warning state does not follow comparator");

  property p_reserved_reads_zero;
    @(posedge mclk) disable iff (rst)
    (bus_setup && hit_resv) |=> (prdata == 32'h0000_0000) && !pslverr;
  endproperty
  a_reserved_reads_zero: assert property (p_reserved_reads_zero)
    else $error("reserved register read nonzero");

  property p_sleep_uses_sleep_mode;
    @(posedge mclk) disable iff (rst)
    (fuse_loaded && pstate == smc_pkg::PS_SLEEP && sleep_mode == smc_pkg::MODE_DISABLED)
      |=> !analog_ctrl.monitor_on;
  endproperty
  a_sleep_uses_sleep_mode: assert property (p_sleep_uses_sleep_mode)
    else $error("disabled sleep mode left monitor on");

endmodule : smc_supply_monitor_control

`default_nettype wire

/* File: verilog/smc_pkg.sv */
/*
  Shared constants and carrier types for the supply monitor control block:
  register indices, field positions, reset values, mode codes and timing.
  Assumes a 250 MHz mclk and a bus whose byte address is four times the index.
*/
`default_nettype none

package smc_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_MONITOR_MODE_CTRL = 6'h00;
  localparam logic [5:0] IDX_THRESHOLD_LEVEL = 6'h01;
  localparam logic [5:0] IDX_RESERVED_FIRST = 6'h02;
  localparam logic [5:0] IDX_RESERVED_LAST = 6'h07;
  localparam logic [5:0] IDX_EARLY_WARN_LEVEL = 6'h08;
  localparam logic [5:0] IDX_WARN_IRQ_CTRL = 6'h09;
  localparam logic [5:0] IDX_WARN_IRQ_FLAGS = 6'h0a;
  localparam logic [5:0] IDX_WARN_STATE = 6'h0b;

  // field positions
  localparam int SLEEP_MODE_LSB = 0;
  localparam int ACTIVE_MODE_LSB = 2;
  localparam int SAMPLE_RATE_BIT = 4;
  localparam int THRESHOLD_LSB = 0;
  localparam int WARN_OFFSET_LSB = 0;
  localparam int WARN_IRQ_ENABLE_BIT = 0;
  localparam int WARN_EDGE_LSB = 1;
  localparam int WARN_IRQ_FLAG_BIT = 0;
  localparam int WARN_BELOW_BIT = 0;

  // reset values
  localparam logic [1:0] RESET_MODE = 2'h0;
  localparam logic [2:0] RESET_THRESHOLD = 3'h0;
  localparam logic [1:0] RESET_WARN_OFFSET = 2'h0;
  localparam logic [1:0] RESET_WARN_EDGE = 2'h0;
  localparam logic [31:0] RESET_RDATA = 32'h0000_0000;

  // unlock guard window, in instructions
  localparam logic [2:0] UNLOCK_WINDOW_INSTR = 3'h4;

  // sampling rates and the derived periods in mclk cycles
  localparam int unsigned MCLK_HZ = 250_000_000;
  localparam int unsigned FAST_RATE_HZ = 128;
  localparam int unsigned SLOW_RATE_HZ = 32;
  localparam int unsigned FAST_CYCLES = MCLK_HZ / FAST_RATE_HZ;
  localparam int unsigned SLOW_CYCLES = MCLK_HZ / SLOW_RATE_HZ;

  // monitor operating modes
  typedef enum logic [1:0] {
    MODE_DISABLED = 2'h0,
    MODE_CONTINUOUS = 2'h1,
    MODE_SAMPLED = 2'h2,
    MODE_CONTINUOUS_HOLD = 2'h3
  } smc_mode_t;

  // warning edge selection
  localparam logic [1:0] EDGE_FALLING = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // warning offset selection; zero switches the warning monitor off
  localparam logic [1:0] WARN_OFFSET_OFF = 2'h0;

  // power state sequencer, gray coded along the usual path
  typedef enum logic [1:0] {
    PS_RUN = 2'b00,
    PS_SLEEP = 2'b01,
    PS_WAKE_HOLD = 2'b11
  } smc_power_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } smc_apb_req_t;

  typedef struct packed {
    logic sample_rate_sel;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
    logic [2:0] threshold_sel;
  } smc_fuse_t;

  typedef struct packed {
    logic monitor_on;
    logic monitor_sampled;
    logic sample_rate_sel;
    logic [2:0] threshold_sel;
    logic warn_on;
    logic [1:0] warn_offset_sel;
  } smc_analog_ctrl_t;

endpackage : smc_pkg

`default_nettype wire

/* File: verilog/smc_sampler.sv */
/*
  Sample strobe generator for the sampled monitor mode.
  Assumes the caller holds run low outside sampled mode; the counter restarts
  whenever run drops or the rate changes so a strobe never comes early.
*/
`timescale 1ns/1ns
`default_nettype none

module smc_sampler #(
  parameter int unsigned FAST_PERIOD = smc_pkg::FAST_CYCLES,
  parameter int unsigned SLOW_PERIOD = smc_pkg::SLOW_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic slow,
  // one-cycle sample pulse
  output logic strobe
);

  logic [31:0] count;
  logic slow_seen;
  wire logic [31:0] period = slow ? 32'(SLOW_PERIOD) : 32'(FAST_PERIOD);
  wire logic restart = !run || (slow != slow_seen);
  wire logic wrap = (count >= period - 32'h0000_0001);
  logic [31:0] next_count;

  assign next_count = (restart || wrap) ? 32'h0000_0000 : count + 32'h0000_0001;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count <= 32'h0000_0000;
      slow_seen <= 1'b0;
      strobe <= 1'b0;
    end
    else
    begin
      count <= next_count;
      slow_seen <= slow;
      strobe <= run && !restart && wrap;
    end
  end

endmodule : smc_sampler

`default_nettype wire

/* File: verif/test_supply_monitor_control.sv */
/*
  Self-checking bench for the supply monitor control block: APB reads
  are checked through an expectation queue, level outputs directly.
  Assumes the design sources and smc_pkg are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module test_supply_monitor_control;
  logic mclk;
  logic rst;
  smc_pkg::smc_apb_req_t apb_req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  smc_pkg::smc_fuse_t fuse;
  logic unlock_key_written;
  logic instr_retired;
  logic deep_sleep;
  logic hold_execution;
  logic warn_below_raw;
  logic monitor_ready;
  smc_pkg::smc_analog_ctrl_t analog_ctrl;
  logic warn_irq;
  int fails;
  int compares;
  // entries are {pslverr, prdata}
  logic [32:0] exp_q[$];

  // short sampling periods keep the sampled-mode waits small
  smc_supply_monitor_control #(.FAST_PERIOD(8), .SLOW_PERIOD(32)) dut (
    .mclk(mclk), .rst(rst), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fuse(fuse),
    .unlock_key_written(unlock_key_written), .instr_retired(instr_retired),
    .deep_sleep(deep_sleep), .hold_execution(hold_execution),
    .warn_below_raw(warn_below_raw), .monitor_ready(monitor_ready),
    .analog_ctrl(analog_ctrl), .warn_irq(warn_irq)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task check_bit(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %b", $time, msg, got);
    end
  endtask : check_bit

  task check_read(input logic [32:0] exp);
    compares++;
    if ({pslverr, prdata} !== exp)
    begin
      fails++;
      $display("wrong value at %0t: read %h expected %h", $time, {pslverr, prdata}, exp);
    end
  endtask : check_read

  // the read data is taken at the edge that completes the access phase
  always @(posedge mclk)
  begin
    if (apb_req.psel && apb_req.penable && pready === 1'b1 && !apb_req.pwrite)
    begin
      if (exp_q.size() == 0)
        check_read(33'h1_FFFF_FFFF);
      else
        check_read(exp_q.pop_front());
    end
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= w;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fails++;
      report_and_stop();
    end
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [32:0] exp);
    exp_q.push_back(exp);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task pulse_instr(input logic key, input int n);
    @(posedge mclk);
    unlock_key_written <= key;
    @(posedge mclk);
    unlock_key_written <= 1'b0;
    // back-to-back instructions, so a full window runs out in four edges
    repeat (n)
    begin
      instr_retired <= 1'b1;
      @(posedge mclk);
    end
    instr_retired <= 1'b0;
  endtask : pulse_instr

  // polls for a raised request, or waits out n cycles for a quiet one
  task irq_check(input logic exp, input int n, input string msg);
    int i;
    i = 0;
    while (i < n && !(exp && warn_irq === 1'b1))
    begin
      @(posedge mclk);
      i++;
    end
    check_bit(warn_irq, exp, msg);
  endtask : irq_check

  task do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : do_reset

  function automatic logic [32:0] ctrl_exp(input logic [1:0] slp);
    return {28'h000_0000, fuse.sample_rate_sel, fuse.active_mode, slp};
  endfunction : ctrl_exp

  initial
  begin
    rst = 1'b1;
    apb_req = '0;
    fuse = '0;
    unlock_key_written = 1'b0;
    instr_retired = 1'b0;
    deep_sleep = 1'b0;
    warn_below_raw = 1'b0;
    monitor_ready = 1'b0;
    fails = 0;
    compares = 0;
    void'($urandom(48));
    fuse.sample_rate_sel = 1'($urandom_range(1));
    fuse.active_mode = 2'h1;
    fuse.sleep_mode = 2'($urandom_range(2));
    fuse.threshold_sel = 3'($urandom_range(3));
    do_reset();
    rd(8'h00, ctrl_exp(fuse.sleep_mode));
    rd(8'h04, {30'h0, fuse.threshold_sel});
    check_bit(analog_ctrl.sample_rate_sel, fuse.sample_rate_sel, "rate");
    check_bit(analog_ctrl.threshold_sel === fuse.threshold_sel, 1'b1, "thr");
    wr(8'h08, 32'hFFFF_FFFF);
    for (int a = 8; a <= 28; a += 4)
      rd(8'(a), 33'h0_0000_0000);
    rd(8'h30, 33'h1_0000_0000);
    rd(8'h21, 33'h1_0000_0000);
    rd(8'h2C, 33'h0_0000_0000);
    wr(8'h00, 32'h0000_001F);
    rd(8'h00, ctrl_exp(fuse.sleep_mode));
    pulse_instr(1'b1, 3);
    wr(8'h00, 32'h0000_001E);
    rd(8'h00, ctrl_exp(2'h2));
    pulse_instr(1'b1, 5);
    wr(8'h00, 32'h0000_0001);
    rd(8'h00, ctrl_exp(2'h2));
    for (int v = 0; v < 4; v++)
    begin
      wr(8'h20, ($urandom() & 32'hFFFF_FFFC) | 32'(v));
      rd(8'h20, 33'(v));
      check_bit(analog_ctrl.warn_offset_sel === 2'(v), 1'b1, "offset");
      check_bit(analog_ctrl.warn_on, v != 0, "warn on");
    end
    wr(8'h20, 32'h0000_0001);
    wr(8'h24, 32'h0000_0000);
    warn_below_raw <= 1'b1;
    irq_check(1'b0, 4, "irq masked");
    rd(8'h28, 33'h0_0000_0001);
    rd(8'h2C, 33'h0_0000_0001);
    wr(8'h28, 32'h0000_0000);
    rd(8'h28, 33'h0_0000_0001);
    wr(8'h28, 32'h0000_0001);
    rd(8'h28, 33'h0_0000_0000);
    warn_below_raw <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(8'h2C, 33'h0_0000_0000);
    for (int e = 0; e < 4; e++)
    begin
      wr(8'h24, {29'h0, 2'(e), 1'b1});
      wr(8'h28, 32'h0000_0001);
      warn_below_raw <= 1'b1;
      irq_check(e == 0 || e == 2, 4, "fall edge");
      wr(8'h28, 32'h0000_0001);
      irq_check(1'b0, 2, "irq cleared");
      warn_below_raw <= 1'b0;
      irq_check(e == 1 || e == 2, 4, "rise edge");
    end
    wr(8'h24, 32'h0000_0005);
    wr(8'h28, 32'h0000_0001);
    deep_sleep <= 1'b1;
    repeat (3) @(posedge mclk);
    check_bit(analog_ctrl.monitor_sampled, 1'b1, "sleep sampled");
    warn_below_raw <= 1'b1;
    irq_check(1'b1, fuse.sample_rate_sel ? 36 : 12, "sampled flag");
    wr(8'h28, 32'h0000_0001);
    deep_sleep <= 1'b0;
    repeat (3) @(posedge mclk);
    check_bit(analog_ctrl.monitor_sampled, 1'b0, "awake");
    // flag holds while monitor is off
    pulse_instr(1'b1, 1);
    wr(8'h00, 32'h0000_0000);
    deep_sleep <= 1'b1;
    repeat (3) @(posedge mclk);
    check_bit(analog_ctrl.monitor_on, 1'b0, "sleep off");
    check_bit(analog_ctrl.warn_on, 1'b0, "warn off");
    warn_below_raw <= 1'b0;
    irq_check(1'b0, 6, "held flag");
    rd(8'h28, 33'h0_0000_0000);
    deep_sleep <= 1'b0;
    fuse.active_mode <= 2'h3;
    do_reset();
    rd(8'h00, ctrl_exp(fuse.sleep_mode));
    deep_sleep <= 1'b1;
    repeat (3) @(posedge mclk);
    deep_sleep <= 1'b0;
    for (int i = 0; i < 4 && hold_execution !== 1'b1; i++)
      @(posedge mclk);
    check_bit(hold_execution, 1'b1, "hold");
    monitor_ready <= 1'b1;
    for (int i = 0; i < 4 && hold_execution !== 1'b0; i++)
      @(posedge mclk);
    check_bit(hold_execution, 1'b0, "release");
    report_and_stop();
  end
endmodule : test_supply_monitor_control

`default_nettype wire
